// ---- hk_pkg.sv ----
// shared constants and types of the housekeeping converter sequencer
package hk_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] HK_ADDR_TEMP_RESULT = 8'h00_D7;
  localparam logic [7:0] HK_ADDR_CONVERT_START = 8'h00_D8;
  localparam logic [7:0] HK_ADDR_BATT_RESULT = 8'h00_DF;
  localparam logic [7:0] HK_ADDR_PWR_INT_EN = 8'h00_EC;
  localparam logic [7:0] HK_ADDR_SUPPLY_RESULT = 8'h00_EF;
  localparam logic [7:0] HK_ADDR_DELTA_CFG = 8'h00_F3;
  localparam logic [7:0] HK_ADDR_PWR_INT_FLAGS = 8'h00_F8;
  localparam logic [7:0] HK_ADDR_STROBE_PERIOD = 8'h00_F9;
  localparam logic [7:0] HK_ADDR_BATT_THRESHOLD = 8'h00_FA;

  // field positions
  localparam int HK_GO_BATT = 0;
  localparam int HK_GO_TEMP = 1;
  localparam int HK_GO_SUPPLY = 2;
  localparam int HK_PER_TEMP_LSB = 0;
  localparam int HK_PER_BATT_LSB = 2;
  localparam int HK_PER_SUPPLY_LSB = 4;
  localparam int HK_DELTA_SUPPLY_LSB = 0;
  localparam int HK_DELTA_TEMP_LSB = 3;
  localparam int HK_LOWBAT_BIT = 0;

  // values after reset
  localparam logic [7:0] HK_RESET_BYTE = 8'h00_00;

  // periodic timing
  localparam longint HK_CLK_HZ = 64'd50_000_000;
  localparam longint HK_MINUTE_S = 64'd60;
  localparam logic [31:0] HK_MINUTE_CYCLES = 32'(HK_MINUTE_S * HK_CLK_HZ);
  localparam logic [4:0] HK_TEMP_MIN_01 = 5'd8;
  localparam logic [4:0] HK_TEMP_MIN_10 = 5'd2;
  localparam logic [4:0] HK_BATT_MIN_01 = 5'd16;
  localparam logic [4:0] HK_BATT_MIN_10 = 5'd4;
  localparam logic [4:0] HK_ANY_MIN_11 = 5'd1;

  localparam logic [2:0] HK_DELTA_OFF = 3'b000;
  localparam logic [2:0] HK_DELTA_EVERY = 3'b111;

  typedef enum logic [1:0] {
    normal_power_mode = 2'd0,
    battery_active_mode = 2'd1,
    sleep_cpu_off_mode = 2'd2
  } hk_mode_t;

  // one result coming back from a converter front end
  typedef struct packed {
    logic done;
    logic [7:0] code;
  } hk_fe_res_t;

  // background period in minutes; zero means background off
  function automatic logic [4:0] hk_period_min(input logic [1:0] sel, input logic batt);
    case (sel)
      2'b01: hk_period_min = batt ? HK_BATT_MIN_01 : HK_TEMP_MIN_01;
      2'b10: hk_period_min = batt ? HK_BATT_MIN_10 : HK_TEMP_MIN_10;
      2'b11: hk_period_min = HK_ANY_MIN_11;
      default: hk_period_min = 5'd0;
    endcase
  endfunction

  function automatic logic [7:0] hk_abs_diff(input logic [7:0] a, input logic [7:0] b);
    hk_abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction
endpackage

// ---- hk_minute_tick.sv ----
// free running one-minute tick for background scheduling
`timescale 1ns/1ps
`default_nettype none
module hk_minute_tick #(
  parameter logic [31:0] MINUTE_CYCLES = hk_pkg::HK_MINUTE_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset
  output logic tick // one cycle pulse per minute
);
  import hk_pkg::*;

  logic [31:0] cnt_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'd0;
      tick <= 1'b0;
    end else if (cnt_q == MINUTE_CYCLES - 32'd1) begin
      cnt_q <= 32'd0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'd1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hk_conv_chan.sv ----
// one converter channel: arbitrates single and background starts
`timescale 1ns/1ps
`default_nettype none
module hk_conv_chan (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic single_req, // pending software request bit
  input wire logic single_ok, // power mode allows single starts
  input wire logic bg_tick, // background interval elapsed
  input wire logic bg_ok, // power mode allows background starts
  input wire hk_pkg::hk_fe_res_t fe_res, // result from the front end
  output logic fe_start, // start pulse to the front end
  output logic accept, // request taken, clears the request bit
  output logic done, // conversion finished, pulse
  output logic done_single, // finished conversion was a single one
  output logic [7:0] code // finished code
);
  import hk_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} hk_chan_st_t;

  hk_chan_st_t state_q;
  logic bg_pend_q;
  logic src_single_q;
  logic start_bg;

  assign accept = (state_q == ST_IDLE) && single_req && single_ok;
  // single requests take precedence over a waiting background slot
  assign start_bg = (state_q == ST_IDLE) && !accept && bg_pend_q && bg_ok;
  assign fe_start = accept || start_bg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bg_pend_q <= 1'b0;
    end else if (bg_tick && bg_ok) begin
      bg_pend_q <= 1'b1;
    end else if (start_bg || !bg_ok) begin
      bg_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      src_single_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fe_start) begin
            state_q <= ST_BUSY;
            src_single_q <= accept;
          end
        end
        ST_BUSY: begin
          if (fe_res.done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      done_single <= 1'b0;
      code <= HK_RESET_BYTE;
    end else begin
      done <= (state_q == ST_BUSY) && fe_res.done;
      done_single <= src_single_q;
      if ((state_q == ST_BUSY) && fe_res.done) begin
        code <= fe_res.code;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hk_adc_seq.sv ----
// housekeeping converter sequencer: registers, scheduling, events
//
// Contract
// - supply result RO, reset zero, updates on interrupt
// - temperature result 8-bit, 0.78 C per step
// - temp request runs one conversion, interrupts after
// - temp background off at reset, nonzero period runs
// - background temp interrupts when delta exceeds setting
// - normal mode: temp background and single both
// - battery mode: temp single only, no background
// - sleep mode: temp background only
// - temp result updates on interrupt, no flag
// - battery result 8-bit, 14.6 mV per step
// - battery request runs one conversion, interrupts after
// - background battery below threshold sets low flag
// - low flag interrupts only while enabled
// - battery mode: battery single only, no background
// - sleep mode: no battery conversions at all
// - flag set on low code or single finish
// - battery result written only when flag sets
// - request bits self-clear on accept; bits 0-2 only
// - temp period 00 off, 8, 2, 1 minutes
// - battery period 00 off, 16, 4, 1 minutes
// - delta 000 off, 1-6 steps, 111 every conversion
`timescale 1ns/1ps
`default_nettype none
module hk_adc_seq #(
  parameter logic [31:0] MINUTE_CYCLES = hk_pkg::HK_MINUTE_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset
  input wire hk_pkg::hk_mode_t power_mode, // current power-saving mode
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, one cycle after address
  output logic temp_start, // temperature front end start
  input wire hk_pkg::hk_fe_res_t temp_fe, // temperature front end result
  output logic batt_start, // battery front end start
  input wire hk_pkg::hk_fe_res_t batt_fe, // battery front end result
  output logic supply_start, // supply input front end start
  input wire hk_pkg::hk_fe_res_t supply_fe, // supply input front end result
  output logic temp_irq, // temperature interrupt pulse
  output logic supply_irq, // supply input interrupt pulse
  output logic psm_irq // power management interrupt level
);
  import hk_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0] go_q;
  logic [5:0] strobe_q;
  logic [5:0] delta_q;
  logic [7:0] thr_q;
  logic low_battery_flag_q;
  logic low_battery_enable_q;
  logic [7:0] temperature_result_q;
  logic [7:0] battery_result_q;
  logic [7:0] supply_input_result_q;
  logic [7:0] temp_ref_q;

  logic wr_go, wr_strobe, wr_delta, wr_thr, wr_flags, wr_en;
  logic temp_accept, batt_accept, supply_accept;
  logic temp_done, batt_done, supply_done;
  logic temp_single, batt_single, supply_single;
  logic [7:0] temp_code, batt_code, supply_code;
  logic temp_hit, batt_set, supply_hit, delta_hit;
  logic [2:0] temp_delta;

  assign wr_go = sfr_wr && (sfr_addr == HK_ADDR_CONVERT_START);
  assign wr_strobe = sfr_wr && (sfr_addr == HK_ADDR_STROBE_PERIOD);
  assign wr_delta = sfr_wr && (sfr_addr == HK_ADDR_DELTA_CFG);
  assign wr_thr = sfr_wr && (sfr_addr == HK_ADDR_BATT_THRESHOLD);
  assign wr_flags = sfr_wr && (sfr_addr == HK_ADDR_PWR_INT_FLAGS);
  assign wr_en = sfr_wr && (sfr_addr == HK_ADDR_PWR_INT_EN);

  // a new software request beats the self-clear of the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      go_q <= 3'b000;
    end else begin
      go_q[HK_GO_BATT] <= (go_q[HK_GO_BATT] && !batt_accept) ||
                          (wr_go && sfr_wdata[HK_GO_BATT]);
      go_q[HK_GO_TEMP] <= (go_q[HK_GO_TEMP] && !temp_accept) ||
                          (wr_go && sfr_wdata[HK_GO_TEMP]);
      go_q[HK_GO_SUPPLY] <= (go_q[HK_GO_SUPPLY] && !supply_accept) ||
                            (wr_go && sfr_wdata[HK_GO_SUPPLY]);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q <= 6'd0;
    end else if (wr_strobe) begin
      strobe_q <= sfr_wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      delta_q <= 6'd0;
    end else if (wr_delta) begin
      delta_q <= sfr_wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_q <= HK_RESET_BYTE;
    end else if (wr_thr) begin
      thr_q <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_battery_enable_q <= 1'b0;
    end else if (wr_en) begin
      low_battery_enable_q <= sfr_wdata[HK_LOWBAT_BIT];
    end
  end

  // writing zero clears the flag; a hardware set in the same cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_battery_flag_q <= 1'b0;
    end else if (batt_set) begin
      low_battery_flag_q <= 1'b1;
    end else if (wr_flags && !sfr_wdata[HK_LOWBAT_BIT]) begin
      low_battery_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      psm_irq <= 1'b0;
    end else begin
      psm_irq <= low_battery_flag_q && low_battery_enable_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // background scheduling

  logic minute;
  logic [4:0] temp_min_q, batt_min_q;
  logic [4:0] temp_per, batt_per;
  logic temp_bg_tick, batt_bg_tick;

  hk_minute_tick #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_tick (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(minute)
  );

  assign temp_per = hk_period_min(strobe_q[HK_PER_TEMP_LSB +: 2], 1'b0);
  assign batt_per = hk_period_min(strobe_q[HK_PER_BATT_LSB +: 2], 1'b1);
  assign temp_bg_tick = minute && (temp_per != 5'd0) && (5'(temp_min_q + 5'd1) >= temp_per);
  assign batt_bg_tick = minute && (batt_per != 5'd0) && (5'(batt_min_q + 5'd1) >= batt_per);

  // the count restarts when the period is off so a new period runs in full
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_min_q <= 5'd0;
    end else if (temp_per == 5'd0 || temp_bg_tick) begin
      temp_min_q <= 5'd0;
    end else if (minute) begin
      temp_min_q <= 5'(temp_min_q + 5'd1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      batt_min_q <= 5'd0;
    end else if (batt_per == 5'd0 || batt_bg_tick) begin
      batt_min_q <= 5'd0;
    end else if (minute) begin
      batt_min_q <= 5'(batt_min_q + 5'd1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channels with power-mode gating

  logic sleep_mode, batt_mode;
  assign sleep_mode = (power_mode == sleep_cpu_off_mode);
  assign batt_mode = (power_mode == battery_active_mode);

  hk_conv_chan u_temp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .single_req(go_q[HK_GO_TEMP]),
    .single_ok(!sleep_mode),
    .bg_tick(temp_bg_tick),
    .bg_ok(!batt_mode),
    .fe_res(temp_fe),
    .fe_start(temp_start),
    .accept(temp_accept),
    .done(temp_done),
    .done_single(temp_single),
    .code(temp_code)
  );

  hk_conv_chan u_batt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .single_req(go_q[HK_GO_BATT]),
    .single_ok(!sleep_mode),
    .bg_tick(batt_bg_tick),
    .bg_ok(power_mode == normal_power_mode),
    .fe_res(batt_fe),
    .fe_start(batt_start),
    .accept(batt_accept),
    .done(batt_done),
    .done_single(batt_single),
    .code(batt_code)
  );

  // supply input runs single conversions only here
  hk_conv_chan u_supply (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .single_req(go_q[HK_GO_SUPPLY]),
    .single_ok(!sleep_mode),
    .bg_tick(1'b0),
    .bg_ok(1'b0),
    .fe_res(supply_fe),
    .fe_start(supply_start),
    .accept(supply_accept),
    .done(supply_done),
    .done_single(supply_single),
    .code(supply_code)
  );

  //////////////////////////////////////////////////////////////////////////////
  // events and results

  assign temp_delta = delta_q[HK_DELTA_TEMP_LSB +: 3];
  assign delta_hit = (temp_delta == HK_DELTA_EVERY) ||
                     ((temp_delta != HK_DELTA_OFF) &&
                      (hk_abs_diff(temp_code, temp_ref_q) > {5'd0, temp_delta}));
  assign temp_hit = temp_done && (temp_single || delta_hit);
  assign batt_set = batt_done && (batt_single || (batt_code < thr_q));
  assign supply_hit = supply_done && supply_single;

  // results hold a code whose weight is fixed by the front end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      temperature_result_q <= HK_RESET_BYTE;
      temp_ref_q <= HK_RESET_BYTE;
      temp_irq <= 1'b0;
    end else begin
      temp_irq <= temp_hit;
      if (temp_hit) begin
        temperature_result_q <= temp_code;
        temp_ref_q <= temp_code;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      battery_result_q <= HK_RESET_BYTE;
    end else if (batt_set) begin
      battery_result_q <= batt_code;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_input_result_q <= HK_RESET_BYTE;
      supply_irq <= 1'b0;
    end else begin
      supply_irq <= supply_hit;
      if (supply_hit) begin
        supply_input_result_q <= supply_code;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= HK_RESET_BYTE;
    end else begin
      case (sfr_addr)
        HK_ADDR_TEMP_RESULT: sfr_rdata <= temperature_result_q;
        HK_ADDR_CONVERT_START: sfr_rdata <= {5'd0, go_q};
        HK_ADDR_BATT_RESULT: sfr_rdata <= battery_result_q;
        HK_ADDR_PWR_INT_EN: sfr_rdata <= {7'd0, low_battery_enable_q};
        HK_ADDR_SUPPLY_RESULT: sfr_rdata <= supply_input_result_q;
        HK_ADDR_DELTA_CFG: sfr_rdata <= {2'd0, delta_q};
        HK_ADDR_PWR_INT_FLAGS: sfr_rdata <= {7'd0, low_battery_flag_q};
        HK_ADDR_STROBE_PERIOD: sfr_rdata <= {2'd0, strobe_q};
        HK_ADDR_BATT_THRESHOLD: sfr_rdata <= thr_q;
        default: sfr_rdata <= HK_RESET_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_supply_result_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(supply_input_result_q) |-> supply_irq)
    else $error("supply result changed without interrupt");

  a_temp_result_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(temperature_result_q) |-> temp_irq)
    else $error("temperature result changed without interrupt");

  a_batt_result_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(battery_result_q) |-> low_battery_flag_q)
    else $error("battery result changed while flag not set");

  a_temp_single_irq: assert property (@(posedge core_clk) disable iff (!arst_n)
    (temp_done && temp_single) |=> temp_irq && (temperature_result_q == $past(temp_code)))
    else $error("single temperature conversion gave no interrupt");

  a_delta_off_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    (temp_done && !temp_single && temp_delta == HK_DELTA_OFF) |=> !temp_irq)
    else $error("delta off but temperature interrupt raised");

  a_go_self_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    (temp_accept && !(wr_go && sfr_wdata[HK_GO_TEMP])) |=> !go_q[HK_GO_TEMP])
    else $error("temperature request bit did not clear");

  a_sleep_no_batt: assert property (@(posedge core_clk) disable iff (!arst_n)
    sleep_mode |-> !batt_start)
    else $error("battery conversion started in sleep mode");

  a_batmode_no_bg: assert property (@(posedge core_clk) disable iff (!arst_n)
    batt_mode |-> (!temp_start || temp_accept) && (!batt_start || batt_accept))
    else $error("background conversion in battery mode");

  a_psm_irq_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    psm_irq |-> $past(low_battery_flag_q) && $past(low_battery_enable_q))
    else $error("power interrupt without enabled flag");

  a_low_batt_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    (batt_done && batt_code < thr_q) |=> low_battery_flag_q)
    else $error("low battery not flagged");
endmodule
`default_nettype wire

// ---- hk_fe_model.sv ----
// behavioural converter front end answering start pulses after a latency
`timescale 1ns/1ps
`default_nettype none
module hk_fe_model #(
  parameter int LAT = 3
) (
  input wire logic core_clk, // system clock
  input wire logic start, // start pulse from the sequencer
  input wire logic [7:0] code_in, // code to return on the next answer
  output var hk_pkg::hk_fe_res_t res // done pulse with code
);
  import hk_pkg::*;
  int cnt = 0;
  logic busy = 1'b0;
  logic done_q = 1'b0;
  logic [7:0] code_q = 8'h00_00;
  assign res = '{done: done_q, code: code_q};
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    done_q <= 1'b0;
    // code is not held outside the answer cycle, so stale reuse shows up
    code_q <= ~code_q;
    if (start) begin
      busy <= 1'b1;
      cnt <= LAT;
    end else if (busy) begin
      if (cnt == 0) begin
        busy <= 1'b0;
        done_q <= 1'b1;
        code_q <= code_in;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hk_adc_seq_bench.sv ----
// self-checking bench of the housekeeping converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module hk_adc_seq_bench;
  import hk_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hk_row_t;
  logic core_clk, arst_n, sfr_wr;
  hk_mode_t power_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, t_code, b_code, s_code, v;
  logic temp_start, batt_start, supply_start, temp_irq, supply_irq, psm_irq;
  hk_fe_res_t temp_fe, batt_fe, supply_fe;
  int n_mismatch, n_checks, n_ts, n_bs, n_ti;
  hk_row_t rows[10];
  hk_adc_seq #(.MINUTE_CYCLES(32'd20)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .power_mode(power_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .temp_start(temp_start), .temp_fe(temp_fe),
    .batt_start(batt_start), .batt_fe(batt_fe), .supply_start(supply_start),
    .supply_fe(supply_fe), .temp_irq(temp_irq), .supply_irq(supply_irq), .psm_irq(psm_irq));
  hk_fe_model fe_t (.core_clk(core_clk), .start(temp_start), .code_in(t_code), .res(temp_fe));
  hk_fe_model fe_b (.core_clk(core_clk), .start(batt_start), .code_in(b_code), .res(batt_fe));
  hk_fe_model fe_s (.core_clk(core_clk), .start(supply_start), .code_in(s_code),
    .res(supply_fe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (temp_start === 1'b1) n_ts++;
    if (batt_start === 1'b1) n_bs++;
    if (temp_irq === 1'b1) n_ti++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  // rdata is registered, so it is taken one full cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    @(negedge core_clk);
    d = sfr_rdata;
  endtask
  task automatic wait_hi(input int sel);
    int i;
    logic s;
    for (i = 0; i < 60; i++) begin
      @(negedge core_clk);
      s = (sel == 0) ? temp_irq : (sel == 1) ? psm_irq : supply_irq;
      if (s === 1'b1) break;
    end
    `CHK("event seen", 1'b1, s)
  endtask
  task automatic idle(input int n);
    n_ts = 0;
    n_bs = 0;
    n_ti = 0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial begin
    arst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00_00;
    sfr_wdata = 8'h00_00;
    power_mode = normal_power_mode;
    t_code = 8'h00_30;
    b_code = 8'h00_80;
    s_code = 8'h00_A5;
    rows = '{'{8'h00_D7, 8'h00_55, 8'h00_00}, '{8'h00_DF, 8'h00_55, 8'h00_00},
      '{8'h00_EF, 8'h00_55, 8'h00_00}, '{8'h00_D8, 8'h00_F8, 8'h00_00},
      '{8'h00_F3, 8'h00_2D, 8'h00_2D}, '{8'h00_FA, 8'h00_40, 8'h00_40},
      '{8'h00_EC, 8'h00_01, 8'h00_01}, '{8'h00_F8, 8'h00_01, 8'h00_00},
      '{8'h00_10, 8'h00_AA, 8'h00_00}, '{8'h00_F9, 8'h00_00, 8'h00_00}};
    do_reset();
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      `CHK("reset value", 8'h00_00, v)
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      `CHK("after write", rows[i].e, v)
    end
    $display("register table done");
    // single temperature then supply conversion
    wr(HK_ADDR_CONVERT_START, 8'h00_02);
    rd(HK_ADDR_CONVERT_START, v);
    `CHK("go bit cleared", 8'h00_00, v)
    wait_hi(0);
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp result", 8'h00_30, v)
    // delta is set again once the first reference code exists
    wr(HK_ADDR_DELTA_CFG, 8'h00_2D);
    wr(HK_ADDR_CONVERT_START, 8'h00_04);
    wait_hi(2);
    rd(HK_ADDR_SUPPLY_RESULT, v);
    `CHK("supply result", 8'h00_A5, v)
    $display("single temperature and supply done");
    // single battery above threshold still sets the flag
    wr(HK_ADDR_CONVERT_START, 8'h00_01);
    wait_hi(1);
    rd(HK_ADDR_BATT_RESULT, v);
    `CHK("batt result", 8'h00_80, v)
    rd(HK_ADDR_PWR_INT_FLAGS, v);
    `CHK("low flag", 8'h00_01, v)
    wr(HK_ADDR_PWR_INT_FLAGS, 8'h00_00);
    rd(HK_ADDR_PWR_INT_FLAGS, v);
    `CHK("flag cleared", 8'h00_00, v)
    `CHK("psm irq off", 1'b0, psm_irq)
    $display("single battery done");
    // background set last, in battery mode it must stay quiet
    power_mode = battery_active_mode;
    wr(HK_ADDR_STROBE_PERIOD, 8'h00_0F);
    idle(100);
    `CHK("temp bg in mode 1", 0, n_ts)
    `CHK("batt bg in mode 1", 0, n_bs)
    $display("battery mode done");
    // normal mode: low battery and a large temperature step
    b_code = 8'h00_20;
    t_code = 8'h00_38;
    power_mode = normal_power_mode;
    idle(60);
    `CHK("temp bg runs", 1, n_ts > 0)
    `CHK("temp delta irq", 1, n_ti > 0)
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp bg result", 8'h00_38, v)
    rd(HK_ADDR_BATT_RESULT, v);
    `CHK("batt bg result", 8'h00_20, v)
    rd(HK_ADDR_PWR_INT_FLAGS, v);
    `CHK("bg low flag", 8'h00_01, v)
    // small step of 2 stays under a delta of 5
    t_code = 8'h00_3A;
    idle(100);
    `CHK("temp bg again", 1, n_ts > 0)
    `CHK("no delta irq", 0, n_ti)
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp held", 8'h00_38, v)
    // delta 111 interrupts on every background conversion
    wr(HK_ADDR_DELTA_CFG, 8'h00_38);
    idle(60);
    `CHK("delta every irq", 1, n_ti > 1)
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp every result", 8'h00_3A, v)
    // delta 000 stays quiet whatever the step; idle(4) lets a late pulse pass
    wr(HK_ADDR_DELTA_CFG, 8'h00_00);
    t_code = 8'h00_50;
    idle(4);
    idle(60);
    `CHK("temp bg delta off", 1, n_ts > 0)
    `CHK("delta off quiet", 0, n_ti)
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp off held", 8'h00_3A, v)
    $display("normal mode done");
    // sleep: temperature background only, no battery at all
    power_mode = sleep_cpu_off_mode;
    wr(HK_ADDR_CONVERT_START, 8'h00_01);
    idle(100);
    `CHK("temp bg in sleep", 1, n_ts > 0)
    `CHK("batt in sleep", 0, n_bs)
    $display("sleep mode done");
    // slow periods: temperature every 8 minutes, battery every 4
    power_mode = normal_power_mode;
    wr(HK_ADDR_STROBE_PERIOD, 8'h00_09);
    idle(10);
    idle(120);
    `CHK("temp 8 min quiet", 0, n_ts)
    `CHK("batt 4 min runs", 1, n_bs > 0)
    idle(60);
    `CHK("temp 8 min runs", 1, n_ts > 0)
    $display("slow periods done");
    // reset in mid-run clears results and periods
    do_reset();
    power_mode = normal_power_mode;
    rd(HK_ADDR_TEMP_RESULT, v);
    `CHK("temp after reset", 8'h00_00, v)
    rd(HK_ADDR_STROBE_PERIOD, v);
    `CHK("period after reset", 8'h00_00, v)
    $display("second reset done");
    close_out();
  end
endmodule
`default_nettype wire
